// *** core/fct_flash_seq.sv ***
/*
  flash command sequencer with temperature readout and wake detection.
  assumes register requests come decoded from the serial link, synchronous
  to clock, one request per cycle at most.
*/
`timescale 1ns/1ps
// Operation
// - command register write starts action; register returns to zero when done
// - code 0x0F ANDs program data into flash byte at program address
// - code 0x40 erases flash bytes 0x00 to 0x1F
// - code 0x41 erases flash bytes 0x20 to 0x3F
// - code 0x42 erases flash bytes 0x40 to 0x5F
// - code 0x45 copies ram into flash page 0
// - code 0x48 copies flash page 0 into ram
// - code 0xF6 sleeps only if wake threshold condition holds
// - sleep ends when the single wire host line differs from its level at the previous clock edge
// - temperature is nine bits, high byte bit 0 is the msb
// - upper seven bits of the high temperature byte read zero
// - sleep entered only if sense magnitude below threshold; bits reset to ones
module fct_flash_seq
  import fct_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register access from the link
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // analog side
  input wire logic [8:0] temp_kelvin,
  input wire logic [7:0] sense_magnitude,
  input wire logic single_wire_host_line,
  // power state
  output logic asleep
);
  // ==========================================================
  // state
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_READ = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_SLEEP = 5'b01000,
    ST_DONE = 5'b10000
  } fct_state_t;

  fct_state_t state_r, state_nxt;
  logic [7:0] flash_command_r, flash_command_nxt;
  logic [7:0] program_data_byte_r, program_data_byte_nxt;
  logic [6:0] program_address_pointer_r, program_address_pointer_nxt;
  logic [2:0] wake_threshold_bits_r, wake_threshold_bits_nxt;
  logic [7:0] temp_low_r, temp_low_nxt;
  logic temp_msb_r, temp_msb_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic line_prev_r, line_prev_nxt;
  logic asleep_r, asleep_nxt;
  logic [7:0] rd_hold_r, rd_hold_nxt;
  logic rd_mem_r, rd_mem_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;

  fct_mem_if mem_bus ();

  fct_mem #(.DEPTH(MEM_DEPTH)) u_mem (
    .clock(clock),
    .port(mem_bus.slave)
  );

  // ==========================================================
  // decode helpers
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // memory address for the source and target of each command
  function automatic logic [6:0] src_addr(input logic [7:0] cmd, input logic [4:0] i,
                                          input logic [6:0] ptr);
    case (cmd)
      CMD_PROG_BYTE: src_addr = ptr;
      CMD_RAM_TO_FLASH: src_addr = MEM_RAM | {2'b00, i};
      default: src_addr = MEM_PAGE0 | {2'b00, i};
    endcase
  endfunction : src_addr

  function automatic logic [6:0] dst_addr(input logic [7:0] cmd, input logic [4:0] i,
                                          input logic [6:0] ptr);
    case (cmd)
      CMD_PROG_BYTE: dst_addr = ptr;
      CMD_ERASE_P1: dst_addr = MEM_PAGE1 | {2'b00, i};
      CMD_ERASE_P2: dst_addr = MEM_PAGE2 | {2'b00, i};
      CMD_FLASH_TO_RAM: dst_addr = MEM_RAM | {2'b00, i};
      default: dst_addr = MEM_PAGE0 | {2'b00, i};
    endcase
  endfunction : dst_addr

  // ==========================================================
  // next state
  always_comb begin
    logic host_mem;
    logic [7:0] a;
    host_mem = 1'b0;
    a = reg_addr;
    state_nxt = state_r;
    flash_command_nxt = flash_command_r;
    program_data_byte_nxt = program_data_byte_r;
    program_address_pointer_nxt = program_address_pointer_r;
    wake_threshold_bits_nxt = wake_threshold_bits_r;
    idx_nxt = idx_r;
    asleep_nxt = asleep_r;
    rd_hold_nxt = BYTE_RST;
    rd_mem_nxt = 1'b0;
    rd_pend_nxt = reg_rd;
    rdata_nxt = rdata_r;
    rvalid_nxt = rd_pend_r;
    mem_bus.en = 1'b0;
    mem_bus.we = 1'b0;
    mem_bus.addr = 7'h00;
    mem_bus.wdata = BYTE_RST;

    // register writes; memory and command only while idle
    if (reg_wr) begin
      case (a)
        ADDR_PROG_DATA: program_data_byte_nxt = reg_wdata;
        ADDR_PROG_ADDR: program_address_pointer_nxt = reg_wdata[6:0];
        ADDR_MODE_WAKE: begin
          // an all-zero threshold code is not valid and is ignored
          if (reg_wdata[WAKE_LSB+:3] != 3'h0) begin
            wake_threshold_bits_nxt = reg_wdata[WAKE_LSB+:3];
          end
        end
        default: ;
      endcase
    end

    // register reads: first stage latches the value
    if (reg_rd) begin
      case (a)
        ADDR_TEMP_LOW: rd_hold_nxt = temp_low_r;
        ADDR_TEMP_HIGH: rd_hold_nxt = {TEMP_HIGH_RSVD, temp_msb_r};
        ADDR_FLASH_CMD: rd_hold_nxt = flash_command_r;
        ADDR_MODE_WAKE: rd_hold_nxt = {4'h0, wake_threshold_bits_r, 1'b0};
        ADDR_PROG_DATA: rd_hold_nxt = program_data_byte_r;
        ADDR_PROG_ADDR: rd_hold_nxt = {1'b0, program_address_pointer_r};
        default: ;
      endcase
    end
    if (rd_pend_r) begin
      rdata_nxt = rd_mem_r ? mem_bus.rdata : rd_hold_r;
    end

    case (state_r)
      ST_IDLE: begin
        idx_nxt = 5'h00;
        host_mem = in_range(a, ADDR_RAM_BASE, ADDR_RAM_LAST) ||
                   (in_range(a, ADDR_FLASH_BASE, ADDR_FLASH_LAST) && !reg_wr);
        if ((reg_wr || reg_rd) && host_mem) begin
          mem_bus.en = 1'b1;
          mem_bus.we = reg_wr;
          mem_bus.addr = a[7] ? (a[6:0] - ADDR_FLASH_BASE[6:0]) : (MEM_RAM | a[6:0]);
          mem_bus.wdata = reg_wdata;
          rd_mem_nxt = reg_rd;
        end
        // commands are taken only here, so a running page walk cannot be retargeted
        if (reg_wr && a == ADDR_FLASH_CMD) begin
          flash_command_nxt = reg_wdata;
          case (reg_wdata)
            CMD_PROG_BYTE, CMD_RAM_TO_FLASH, CMD_FLASH_TO_RAM: state_nxt = ST_READ;
            CMD_ERASE_P0, CMD_ERASE_P1, CMD_ERASE_P2: state_nxt = ST_WRITE;
            CMD_POWER_DOWN: begin
              if (sense_magnitude < wake_level(wake_threshold_bits_r)) begin
                state_nxt = ST_SLEEP;
                asleep_nxt = 1'b1;
              end else begin
                state_nxt = ST_DONE;
              end
            end
            default: state_nxt = ST_DONE;
          endcase
        end
      end
      ST_READ: begin
        mem_bus.en = 1'b1;
        mem_bus.addr = src_addr(flash_command_r, idx_r, program_address_pointer_r);
        state_nxt = ST_WRITE;
      end
      ST_WRITE: begin
        mem_bus.en = 1'b1;
        mem_bus.we = 1'b1;
        mem_bus.addr = dst_addr(flash_command_r, idx_r, program_address_pointer_r);
        case (flash_command_r)
          CMD_PROG_BYTE: mem_bus.wdata = program_data_byte_r & mem_bus.rdata;
          CMD_ERASE_P0, CMD_ERASE_P1, CMD_ERASE_P2:
            mem_bus.wdata = ERASED_BYTE;
          default: mem_bus.wdata = mem_bus.rdata;
        endcase
        // page commands walk 32 bytes, the byte program only one
        if (flash_command_r == CMD_PROG_BYTE || idx_r == PAGE_LAST) begin
          state_nxt = ST_DONE;
        end else begin
          idx_nxt = idx_r + 5'h01;
          state_nxt = (flash_command_r == CMD_RAM_TO_FLASH ||
                       flash_command_r == CMD_FLASH_TO_RAM) ? ST_READ : ST_WRITE;
        end
      end
      ST_SLEEP: begin
        if (single_wire_host_line != line_prev_r) begin
          asleep_nxt = 1'b0;
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        // the command reads back nonzero until here, so a host poll sees
        // completion only after the last memory write has landed
        flash_command_nxt = CMD_NONE;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      flash_command_r <= BYTE_RST;
      program_data_byte_r <= BYTE_RST;
      program_address_pointer_r <= 7'h00;
      wake_threshold_bits_r <= WAKE_RST;
      idx_r <= 5'h00;
      asleep_r <= 1'b0;
      rd_hold_r <= BYTE_RST;
      rd_mem_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rdata_r <= BYTE_RST;
      rvalid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      flash_command_r <= flash_command_nxt;
      program_data_byte_r <= program_data_byte_nxt;
      program_address_pointer_r <= program_address_pointer_nxt;
      wake_threshold_bits_r <= wake_threshold_bits_nxt;
      idx_r <= idx_nxt;
      asleep_r <= asleep_nxt;
      rd_hold_r <= rd_hold_nxt;
      rd_mem_r <= rd_mem_nxt;
      rd_pend_r <= rd_pend_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ==========================================================
  // sensor and line sampling
  // the line is compared with its level at the previous edge, so a pulse
  // that starts and ends between two clock edges is not seen as a wake edge
  always_comb begin
    temp_low_nxt = temp_kelvin[7:0];
    temp_msb_nxt = temp_kelvin[8];
    line_prev_nxt = single_wire_host_line;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      temp_low_r <= BYTE_RST;
      temp_msb_r <= 1'b0;
      line_prev_r <= 1'b0;
    end else begin
      temp_low_r <= temp_low_nxt;
      temp_msb_r <= temp_msb_nxt;
      line_prev_r <= line_prev_nxt;
    end
  end

  // ==========================================================
  // elaboration checks on the shared layout
  // the page walk counts with a five-bit index, so pages, the ram window and
  // the flash window must all agree with it
  if (MEM_DEPTH != (1 << MEM_AW)) begin : g_chk_depth
    $error("fct_flash_seq: memory depth and address width disagree");
  end
  if (int'(PAGE_LAST) != int'(ADDR_RAM_LAST - ADDR_RAM_BASE)) begin : g_chk_page
    $error("fct_flash_seq: ram window and page size disagree");
  end
  if (int'(MEM_PAGE1 - MEM_PAGE0) != int'(PAGE_LAST) + 1) begin : g_chk_stride
    $error("fct_flash_seq: flash pages are not contiguous");
  end
  if (int'(ADDR_FLASH_LAST - ADDR_FLASH_BASE) != int'(MEM_PAGE2) + int'(PAGE_LAST)) begin : g_chk_flash
    $error("fct_flash_seq: flash window does not cover the pages");
  end
  if (int'(MEM_RAM) + int'(PAGE_LAST) >= MEM_DEPTH) begin : g_chk_ram
    $error("fct_flash_seq: ram does not fit in the memory");
  end
  if (WAKE_LSB + 3 > 8) begin : g_chk_wake
    $error("fct_flash_seq: wake field leaves the register");
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign asleep = asleep_r;
endmodule : fct_flash_seq

// *** core/fct_pkg.sv ***
/*
  constants shared by the flash command sequencer and its memory.
  assumes an 8-bit register space reached by an already decoded link.
*/
package fct_pkg;
  // ==========================================================
  // register offsets on the link
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h60;
  localparam logic [7:0] ADDR_TEMP_HIGH = 8'h61;
  localparam logic [7:0] ADDR_FLASH_CMD = 8'h62;
  localparam logic [7:0] ADDR_MODE_WAKE = 8'h64;
  localparam logic [7:0] ADDR_PROG_DATA = 8'h6F;
  localparam logic [7:0] ADDR_PROG_ADDR = 8'h70;
  // host windows onto the memories
  localparam logic [7:0] ADDR_RAM_BASE = 8'h00;
  localparam logic [7:0] ADDR_RAM_LAST = 8'h1F;
  localparam logic [7:0] ADDR_FLASH_BASE = 8'h80;
  localparam logic [7:0] ADDR_FLASH_LAST = 8'hDF;

  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_PROG_BYTE = 8'h0F;
  localparam logic [7:0] CMD_ERASE_P0 = 8'h40;
  localparam logic [7:0] CMD_ERASE_P1 = 8'h41;
  localparam logic [7:0] CMD_ERASE_P2 = 8'h42;
  localparam logic [7:0] CMD_RAM_TO_FLASH = 8'h45;
  localparam logic [7:0] CMD_FLASH_TO_RAM = 8'h48;
  localparam logic [7:0] CMD_POWER_DOWN = 8'hF6;

  // ==========================================================
  // memory layout: flash 0x00..0x5F, ram 0x60..0x7F
  localparam int MEM_AW = 7;
  localparam int MEM_DEPTH = 128;
  localparam logic [6:0] MEM_PAGE0 = 7'h00;
  localparam logic [6:0] MEM_PAGE1 = 7'h20;
  localparam logic [6:0] MEM_PAGE2 = 7'h40;
  localparam logic [6:0] MEM_RAM = 7'h60;
  localparam logic [4:0] PAGE_LAST = 5'h1F;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ==========================================================
  // field positions and reset values
  localparam int WAKE_LSB = 1;
  localparam logic [2:0] WAKE_RST = 3'h7;
  localparam logic [6:0] TEMP_HIGH_RSVD = 7'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // sleep threshold scaled from the wake code
  function automatic logic [7:0] wake_level(input logic [2:0] code);
    wake_level = {code, 5'h00};
  endfunction : wake_level
endpackage : fct_pkg

// *** core/fct_mem_if.sv ***
/*
  single-port byte memory port between sequencer and memory.
  assumes one clock; read data arrive one cycle after the request.
*/
`timescale 1ns/1ps
interface fct_mem_if;
  logic en;
  logic we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output en, output we, output addr, output wdata, input rdata);
  modport slave (input en, input we, input addr, input wdata, output rdata);
endinterface : fct_mem_if

// *** core/fct_mem.sv ***
/*
  byte memory holding flash and ram, registered read data.
  assumes reset contents do not matter; flash starts erased in simulation only by writes.
*/
`timescale 1ns/1ps
module fct_mem
  import fct_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH
) (
  // clock
  input wire logic clock,
  // access port
  fct_mem_if.slave port
);
  // ==========================================================
  // storage
  logic [7:0] mem_r [DEPTH];
  logic [7:0] rdata_r;

  if (DEPTH > (1 << MEM_AW)) begin : g_chk
    $error("fct_mem: depth exceeds address range");
  end

  always_ff @(posedge clock) begin
    if (port.en && port.we) begin
      mem_r[port.addr] <= port.wdata;
    end
    if (port.en && !port.we) begin
      rdata_r <= mem_r[port.addr];
    end
  end

  assign port.rdata = rdata_r;
endmodule : fct_mem

// *** bench/fct_flash_seq_properties.sv ***
/*
  port checker for fct_flash_seq, attached by bind.
  assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module fct_flash_seq_properties
  import fct_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // analog side and power
  input wire logic [8:0] temp_kelvin,
  input wire logic [7:0] sense_magnitude,
  input wire logic single_wire_host_line,
  input wire logic asleep
);
  // ==========================================================
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire pd_wr = reg_wr && reg_addr == ADDR_FLASH_CMD && reg_wdata == CMD_POWER_DOWN;

  read_answer_a: assert property (reg_rd |-> ##2 reg_rvalid)
    else $error("read not answered");
  answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd, 2))
    else $error("answer without read");
  temp_rsvd_zero_a: assert property (reg_rvalid && $past(reg_addr, 2) == ADDR_TEMP_HIGH
    |-> reg_rdata[7:1] == TEMP_HIGH_RSVD) else $error("reserved bits set");
  temp_msb_a: assert property (reg_rvalid && $past(reg_addr, 2) == ADDR_TEMP_HIGH
    && $past(temp_kelvin, 4) == temp_kelvin |-> reg_rdata[0] == temp_kelvin[8])
    else $error("temperature msb wrong");
  temp_low_a: assert property (reg_rvalid && $past(reg_addr, 2) == ADDR_TEMP_LOW
    && $past(temp_kelvin, 4) == temp_kelvin |-> reg_rdata == temp_kelvin[7:0])
    else $error("temperature low wrong");
  sleep_cause_a: assert property ($rose(asleep) |-> $past(pd_wr, 1) || $past(pd_wr, 2))
    else $error("sleep without command");
  wake_edge_a: assert property (asleep && single_wire_host_line != $past(single_wire_host_line)
    |-> ##[1:2] !asleep) else $error("no wake on line edge");
  sleep_hold_a: assert property ($fell(asleep) |->
    $past(single_wire_host_line, 1) != $past(single_wire_host_line, 2)
    || $past(single_wire_host_line, 2) != $past(single_wire_host_line, 3))
    else $error("woke without line edge");

  cover property ($rose(asleep));
  cover property ($fell(asleep));
  cover property (reg_rvalid && $past(reg_addr, 2) == ADDR_TEMP_HIGH);
endmodule : fct_flash_seq_properties

bind fct_flash_seq fct_flash_seq_properties chk_u (.clock(clock), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .temp_kelvin(temp_kelvin),
  .sense_magnitude(sense_magnitude), .single_wire_host_line(single_wire_host_line),
  .asleep(asleep));

// *** bench/fct_host_model.sv ***
/*
  host side model: temperature, sense level and the single-wire line.
  assumes the bench sets levels by non-blocking assignment at clock edges.
*/
`timescale 1ns/1ps
module fct_host_model (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // settings from the bench
  input wire logic [8:0] temp_set,
  input wire logic [7:0] sense_set,
  input wire logic line_flip,
  // levels toward the device
  output logic [8:0] temp_kelvin,
  output logic [7:0] sense_magnitude,
  output logic single_wire_host_line
);
  // ==========================================================
  // levels lag the bench one cycle, like a slow sensor
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      temp_kelvin <= 9'h000;
      sense_magnitude <= 8'h00;
      single_wire_host_line <= 1'b0;
    end else begin
      temp_kelvin <= temp_set;
      sense_magnitude <= sense_set;
      single_wire_host_line <= single_wire_host_line ^ line_flip;
    end
  end
endmodule : fct_host_model

// *** bench/fct_flash_seq_tb_top.sv ***
/*
  self-checking bench for fct_flash_seq.
  assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module fct_flash_seq_tb_top
  import fct_pkg::*;
;
  logic clock, resetn, reg_wr, reg_rd, reg_rvalid, line_flip, asleep, line;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, sense_set, sense, v;
  logic [8:0] temp_set, temp;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  fct_flash_seq dut_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .temp_kelvin(temp), .sense_magnitude(sense), .single_wire_host_line(line), .asleep(asleep));
  fct_host_model host_u (.clock(clock), .resetn(resetn), .temp_set(temp_set),
    .sense_set(sense_set), .line_flip(line_flip), .temp_kelvin(temp),
    .sense_magnitude(sense), .single_wire_host_line(line));

  // ==========================================================
  // tasks
  task automatic print_verdict;
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // the answer stands for one cycle, right after the edge that follows the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    #1;
    chk({7'h00, reg_rvalid}, 8'h01);
    d = reg_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    chk(v, e);
  endtask : rd_chk

  // polling is bounded so a stuck command cannot hang the run
  task automatic run_cmd(input logic [7:0] code);
    int n;
    n = 0;
    wr(ADDR_FLASH_CMD, code);
    v = code;
    while (v !== CMD_NONE && n < 200) begin
      rd(ADDR_FLASH_CMD, v);
      n++;
    end
    chk(v, CMD_NONE);
  endtask : run_cmd

  function automatic logic [7:0] pat(input int i);
    pat = 8'(i) * 8'h1D + 8'h07;
  endfunction : pat

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    temp_set = 9'h1A5;
    sense_set = 8'h00;
    line_flip = 1'b0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    rd_chk(ADDR_MODE_WAKE, {4'h0, WAKE_RST, 1'b0});
    rd_chk(ADDR_FLASH_CMD, CMD_NONE);
    wr(ADDR_MODE_WAKE, 8'h00);
    rd_chk(ADDR_MODE_WAKE, {4'h0, WAKE_RST, 1'b0});
    wr(ADDR_TEMP_LOW, 8'h00);
    rd_chk(ADDR_TEMP_LOW, 8'hA5);
    rd(ADDR_TEMP_HIGH, v);
    chk(v & 8'h01, 8'h01);
    chk(v, 8'h01);
    for (int i = 0; i < 32; i++) begin
      wr(ADDR_RAM_BASE + 8'(i), pat(i));
    end
    run_cmd(CMD_ERASE_P1);
    run_cmd(CMD_ERASE_P2);
    run_cmd(CMD_ERASE_P0);
    for (int i = 0; i < 96; i++) begin
      rd_chk(ADDR_FLASH_BASE + 8'(i), ERASED_BYTE);
    end
    run_cmd(CMD_RAM_TO_FLASH);
    for (int i = 0; i < 33; i++) begin
      rd_chk(ADDR_FLASH_BASE + 8'(i), (i < 32) ? pat(i) : ERASED_BYTE);
    end
    wr(ADDR_PROG_DATA, 8'h5A);
    wr(ADDR_PROG_ADDR, 8'h03);
    run_cmd(CMD_PROG_BYTE);
    rd_chk(ADDR_FLASH_BASE + 8'h03, pat(3) & 8'h5A);
    rd_chk(ADDR_FLASH_BASE + 8'h04, pat(4));
    for (int i = 0; i < 32; i++) begin
      wr(ADDR_RAM_BASE + 8'(i), 8'h00);
    end
    run_cmd(CMD_FLASH_TO_RAM);
    for (int i = 0; i < 32; i++) begin
      rd_chk(ADDR_RAM_BASE + 8'(i), (i == 3) ? (pat(3) & 8'h5A) : pat(i));
    end
    run_cmd(8'h33);
    rd_chk(ADDR_RAM_BASE + 8'h05, pat(5));
    rd_chk(ADDR_FLASH_BASE + 8'h05, pat(5));
    // threshold 32: a magnitude of exactly 32 must not sleep
    wr(ADDR_MODE_WAKE, 8'h02);
    sense_set <= 8'h20;
    run_cmd(CMD_POWER_DOWN);
    chk({7'h00, asleep}, 8'h00);
    sense_set <= 8'h1F;
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_FLASH_CMD, CMD_POWER_DOWN);
      repeat (20) @(posedge clock);
      #1;
      chk({7'h00, asleep}, 8'h01);
      @(posedge clock);
      line_flip <= 1'b1;
      @(posedge clock);
      line_flip <= 1'b0;
      repeat (4) @(posedge clock);
      #1;
      chk({7'h00, asleep}, 8'h00);
      rd_chk(ADDR_FLASH_CMD, CMD_NONE);
    end
    print_verdict();
  end
endmodule : fct_flash_seq_tb_top
